/* File: pkg/modem_test_pkg.sv */
// Package for the modem test generator and receive-state control block.
// Assumes a single 10 MHz modem clock and a plain strobe register port.
package modem_test_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] RNG_SEED_ADDR           = 16'h2263;
  localparam logic [15:0] TEST_PACKET_LENGTH_ADDR = 16'h226D;
  localparam logic [15:0] TONE_FREQUENCY_ADDR     = 16'h226E;
  localparam logic [15:0] MODEM_STATE_STATUS_ADDR = 16'h2270;
  localparam logic [15:0] TEST_CONTROL_ADDR       = 16'h2280;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0]  RNG_SEED_RESET     = 8'h01;
  localparam logic [7:0]  PKT_LEN_RESET      = 8'h01;
  localparam logic [7:0]  TONE_STEP_RESET    = 8'h04;
  localparam logic [4:0]  GAP_RESET          = 5'h1F;
  localparam int          LOCK_BIT           = 7;
  localparam int          RX_FIELD_LSB       = 4;
  localparam logic [6:0]  PKT_LEN_MIN        = 7'h01;
  localparam logic [6:0]  PKT_LEN_MAX        = 7'h7F;
  localparam logic [15:0] CRC_POLY           = 16'h1021;
  localparam logic [7:0]  DAC_MID            = 8'h80;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 10;
  localparam int SYMBOL_US      = 16;
  localparam int SYMBOL_CYCLES  = SYMBOL_US * CLK_MHZ;
  localparam int HEADER_SYMBOLS = 12;  // preamble, delimiter, length
  localparam int PKT_MIN_US     = 256;
  localparam int PKT_MAX_US     = 4256;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE, RX_PACKET_DETECT, RX_TIMING_WAIT, RX_COARSE_ONE,
    RX_COARSE_TWO, RX_SYMBOL_ONE, RX_SYMBOL_TWO, RX_PACKET_END
  } rx_state_t;

  typedef enum {GEN_IDLE, GEN_PACKET, GEN_GAP} gen_state_t;

  typedef struct packed {
    logic [7:0] iData;
    logic [7:0] qData;
  } dac_sample_t;

endpackage

/* File: verilog/sync_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ns
module sync_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in wrap bit
  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

/* File: verilog/modem_test_gen.sv */
// Test generator: random symbols, test packets, single tone, rx state control.
// Assumes the modulator pulls symbols with symReady; DAC runs on clk.
`timescale 1ns/1ns

module modem_test_gen
  import modem_test_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [7:0]       regRdata,
  // Demodulator state machine
  input  wire rx_state_t   rxStateNext,
  output rx_state_t        rxState,
  output logic             rxForce,
  // Symbol stream to modulator
  output logic             symValid,
  input  wire logic        symReady,
  output logic [3:0]       symData,
  output logic             pktActive,
  // DAC samples
  output dac_sample_t      dacSample
);

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // 0x2263  seed       8-bit start value of the random generator; zero
  //                    pins the shift structure at zero, so keep it nonzero
  // 0x226D  length     [6:0] payload bytes; 0 is stored as 1
  // 0x226E  tone step  phase increment; values below 4 are stored as 4
  // 0x2270  status     [7] lock, active low; [6:4] receive state field
  // 0x2280  control    [0] generator on, [1] tone on, [3:2] I route,
  //                    [5:4] Q route, [7:6] nonzero loads gap {bits, 111}
  // Route codes: 0 cosine, 1 sine, 2 and 3 hold the line at mid-scale.
  // Reads of control show packet activity in bit 7; bit 6 reads zero.
  // Read data is zero in every cycle after one without a read strobe, so a stale
  // value can never be taken for an answer.
  // Unmapped addresses read zero and ignore writes.
  //
  // Receive-state codes
  //   000 idle after reset
  //   001 waiting for a packet
  //   010 waiting for timing synchronisation
  //   011 coarse offset, first stage
  //   100 coarse offset, second stage
  //   101 to 111 later demodulator stages, pinned by the lock like the others
  // With the lock low the reported state is pinned to the field one
  // clock after the write; with it high the field is only a record.

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]  seed_q;
  logic [6:0]  pktLen_q;
  logic [7:0]  toneStep_q;
  logic        lockN_q;
  rx_state_t   rxField_q;
  rx_state_t   rxState_q;
  logic        genEn_q;
  logic        toneEn_q;
  logic [1:0]  routeI_q;
  logic [1:0]  routeQ_q;
  logic [4:0]  gap_q;
  logic [6:0]  lenClamp;

  // A zero length clamps to PKT_LEN_MIN; bit 7 of the written byte is dropped, not clamped
  always_comb begin
    lenClamp = regWdata[6:0];
    if (lenClamp < PKT_LEN_MIN) lenClamp = PKT_LEN_MIN;
  end

  // Software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seed_q     <= RNG_SEED_RESET;
      pktLen_q   <= PKT_LEN_RESET[6:0];
      toneStep_q <= TONE_STEP_RESET;
      lockN_q    <= 1'b1;
      rxField_q  <= RX_IDLE;
      genEn_q    <= 1'b0;
      toneEn_q   <= 1'b0;
      routeI_q   <= 2'h0;
      routeQ_q   <= 2'h1;
      gap_q      <= GAP_RESET;
    end else if (regWrite) begin
      unique case (regAddr)
        RNG_SEED_ADDR:           seed_q <= regWdata;
        TEST_PACKET_LENGTH_ADDR: pktLen_q <= lenClamp;
        TONE_FREQUENCY_ADDR: begin
          // Below 4 the tone would fall under 1/256 of fDAC
          toneStep_q <= (regWdata < 8'h04) ? 8'h04 : regWdata;
        end
        MODEM_STATE_STATUS_ADDR: begin
          lockN_q   <= regWdata[LOCK_BIT];
          rxField_q <= rx_state_t'(regWdata[RX_FIELD_LSB +: 3]);
        end
        TEST_CONTROL_ADDR: begin
          genEn_q  <= regWdata[0];
          toneEn_q <= regWdata[1];
          routeI_q <= regWdata[3:2];
          routeQ_q <= regWdata[5:4];
          gap_q    <= regWdata[7:6] == 2'h0 ? gap_q : {regWdata[7:6], 3'h7};
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Demodulator state lock-up
  // ---------------------------------------------------------------
  // Locked: held at the recorded field; free: follows the demodulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_q <= RX_IDLE;
    end else if (!lockN_q) begin
      rxState_q <= rxField_q;
    end else begin
      rxState_q <= rxStateNext;
    end
  end
  assign rxState = rxState_q;
  assign rxForce = !lockN_q;

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        RNG_SEED_ADDR:           regRdata <= seed_q;
        TEST_PACKET_LENGTH_ADDR: regRdata <= {1'b0, pktLen_q};
        TONE_FREQUENCY_ADDR:     regRdata <= toneStep_q;
        MODEM_STATE_STATUS_ADDR: regRdata <= {lockN_q, rxState_q, 4'h0};
        TEST_CONTROL_ADDR: begin
          regRdata <= {pktActive, 1'b0, routeQ_q, routeI_q, toneEn_q, genEn_q};
        end
        default:                 regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
  // ---------------------------------------------------------------
  // Random generator
  // ---------------------------------------------------------------
  logic [15:0] crc_q;
  logic [15:0] crcNext;
  logic        fifoReady;
  logic        genSym;

  // Four serial CRC steps per symbol
  always_comb begin
    crcNext = crc_q;
    for (int i = 0; i < 4; i++) begin
      crcNext = crcNext[15] ? ((crcNext << 1) ^ CRC_POLY) : (crcNext << 1);
    end
  end

  // The generator reloads only while idle, not in the gaps, so every burst of
  // packets starts from the same sequence for a given seed. A zero
  // seed keeps the register at zero and yields constant symbols.
  // Seed reload whenever the generator is idle; zero seed is software's fault
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_q <= 16'h0001;
    end else if (!pktActive) begin
      crc_q <= {seed_q, seed_q};
    end else if (genSym) begin
      crc_q <= crcNext;
    end
  end

  // ---------------------------------------------------------------
  // Packet and gap sequencing
  // ---------------------------------------------------------------
  // A packet is a fixed header of HEADER_SYMBOLS slots plus two slots
  // per payload byte, one slot every SYMBOL_CYCLES clocks. The gap that
  // follows is counted in the same slots, so packet and gap share one
  // grid. Clearing the enable never cuts a packet short: the current
  // packet and its gap always complete, so a measuring receiver never
  // sees a truncated frame.
  // The count needs nine bits: the longest packet has 266 slots.
  gen_state_t  gen_q;
  logic [8:0]  symLeft_q;
  logic [8:0]  symTimer_q;
  logic        symTick;
  logic [4:0]  gapLeft_q;

  // Symbol pacing: one per 16 us, so payload+header sets packet time
  assign symTick = symTimer_q == 9'(SYMBOL_CYCLES - 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      symTimer_q <= '0;
    end else if (gen_q == GEN_IDLE || symTick) begin
      symTimer_q <= '0;
    end else begin
      symTimer_q <= symTimer_q + 1'b1;
    end
  end

  // A full FIFO at a tick defers the symbol to the next slot; the pacing timer runs on
  assign genSym = gen_q == GEN_PACKET && symTick && fifoReady;
  assign pktActive = gen_q != GEN_IDLE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_q     <= GEN_IDLE;
      symLeft_q <= '0;
      gapLeft_q <= '0;
    end else begin
      unique case (gen_q)
        GEN_IDLE: if (genEn_q) begin
          gen_q     <= GEN_PACKET;
          // Two symbols per byte plus header: 224 us to 4256 us
          symLeft_q <= 9'(HEADER_SYMBOLS) + {1'b0, pktLen_q, 1'b0} - 9'h001;
        end
        GEN_PACKET: if (genSym) begin
          if (symLeft_q == 9'h000) begin
            gen_q     <= GEN_GAP;
            gapLeft_q <= gap_q;
          end else begin
            symLeft_q <= symLeft_q - 9'h001;
          end
        end
        GEN_GAP: if (symTick || gapLeft_q == 5'h00) begin
          if (gapLeft_q == 5'h00) begin
            gen_q <= genEn_q ? GEN_PACKET : GEN_IDLE;
            symLeft_q <= 9'(HEADER_SYMBOLS) + {1'b0, pktLen_q, 1'b0} - 9'h001;
          end else begin
            gapLeft_q <= gapLeft_q - 5'h01;
          end
        end
      endcase
    end
  end

  // Symbol FIFO toward the modulator
  sync_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) symFifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .inValid  (genSym),
    .inReady  (fifoReady),
    .inData   (crc_q[15:12]),
    .outValid (symValid),
    .outReady (symReady),
    .outData  (symData)
  );

  // ---------------------------------------------------------------
  // Single-tone generator
  // ---------------------------------------------------------------
  logic [9:0] phase_q;
  logic [7:0] cosVal;
  logic [7:0] sinVal;

  // The accumulator wraps at 1024, so the tone period is 1024/step
  // clocks; steps that do not divide 1024 give a slightly jittered
  // tone, the price of a table with no interpolation.
  // Phase step per DAC clock: f = fDAC * step / 1024
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
    end else if (toneEn_q) begin
      phase_q <= phase_q + {2'b00, toneStep_q};
    end else begin
      phase_q <= '0;
    end
  end

  // Coarse quarter-wave sine, offset binary around mid-scale
  function automatic logic [7:0] wave(input logic [9:0] ph);
    logic [7:0] idx;
    logic [6:0] mag;
    idx = ph[8] ? ~ph[7:0] : ph[7:0];
    mag = (idx[7:6] == 2'h3) ? 7'h7F : {idx[7:6], idx[7:3]} + 7'(idx[7:2]);
    return ph[9] ? DAC_MID - {1'b0, mag} : DAC_MID + {1'b0, mag};
  endfunction
  assign sinVal = wave(phase_q);
  assign cosVal = wave(phase_q + 10'h100);

  // Route: 0 cos, 1 sin, other mid-scale
  function automatic logic [7:0] pick(input logic [1:0] r, input logic [7:0] c,
                                      input logic [7:0] s);
    return r == 2'h0 ? c : (r == 2'h1 ? s : DAC_MID);
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dacSample <= '{iData: 8'h80, qData: 8'h80};
    end else if (toneEn_q) begin
      dacSample.iData <= pick(routeI_q, cosVal, sinVal);
      dacSample.qData <= pick(routeQ_q, cosVal, sinVal);
    end else begin
      dacSample <= '{iData: DAC_MID, qData: DAC_MID};
    end
  end
endmodule

/* File: bench/modem_test_gen_properties.sv */
// Port checker for the modem test generator.
// Assumes it is bound to modem_test_gen and sees only its ports.
`timescale 1ns/1ns
module modem_test_gen_properties
  import modem_test_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  // State machine and stream
  input wire rx_state_t   rxStateNext,
  input wire rx_state_t   rxState,
  input wire logic        rxForce,
  input wire logic        symValid,
  input wire logic        symReady,
  input wire logic [3:0]  symData
);
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Read data stands one cycle only, so a stale value is a fault
  property p_rdIdle; !regRead |=> regRdata == 8'h00; endproperty
  property p_rdStatus;
    regRead && regAddr == MODEM_STATE_STATUS_ADDR |=>
      regRdata == {!$past(rxForce), 3'($past(rxState)), 4'h0};
  endproperty
  property p_unmapped; regRead && regAddr[15:8] != 8'h22 |=> regRdata == 8'h00; endproperty
  property p_lockSet;
    regWrite && regAddr == MODEM_STATE_STATUS_ADDR && !regWdata[7] |=>
      rxForce ##1 {1'b0, rxState, 4'h0} == ($past(regWdata, 2) & 8'h70);
  endproperty
  property p_lockClr;
    regWrite && regAddr == MODEM_STATE_STATUS_ADDR && regWdata[7] |=> !rxForce;
  endproperty
  property p_forceHold;
    (rxForce && !regWrite) ##1 (rxForce && !regWrite) |=> $stable(rxState);
  endproperty
  property p_follow; !rxForce |=> rxState == $past(rxStateNext); endproperty
  property p_resetIdle; $rose(arst_n) |-> rxState == RX_IDLE; endproperty
  property p_symHold; symValid && !symReady |=> symValid && $stable(symData); endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero");
  a_rdStatus: assert property (p_rdStatus) else $error("status read wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_lockSet: assert property (p_lockSet) else $error("lock did not force");
  a_lockClr: assert property (p_lockClr) else $error("lock did not release");
  a_forceHold: assert property (p_forceHold) else $error("forced state moved");
  a_follow: assert property (p_follow) else $error("state not following");
  a_resetIdle: assert property (p_resetIdle) else $error("state not idle");
  a_symHold: assert property (p_symHold) else $error("symbol dropped");
  c_force: cover property (rxForce);
  c_sym: cover property (symValid && symReady);
  c_status: cover property (regRead && regAddr == MODEM_STATE_STATUS_ADDR);
endmodule

bind modem_test_gen modem_test_gen_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .rxStateNext(rxStateNext), .rxState(rxState), .rxForce(rxForce),
  .symValid(symValid), .symReady(symReady), .symData(symData));

/* File: bench/rf_partner.sv */
// Far-side model: modulator symbol sink in front of the RF block.
// Assumes a valid/ready symbol stream on the modem clock.
`timescale 1ns/1ns
module rf_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Stall request from the bench
  input  wire logic       stall,
  // Symbol stream
  input  wire logic       symValid,
  output logic            symReady,
  input  wire logic [3:0] symData,
  // Counts
  output int              symCount,
  output int              symFlips
);
  // ------------
  // Sink
  // ------------
  logic [2:0] slot_q;
  logic [3:0] last_q;
  // Slow mode refuses one cycle in eight so the FIFO must hold data
  assign symReady = !(stall && slot_q == 3'h7);
  // Count taken symbols and changes between neighbours
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_q   <= 3'h0;
      last_q   <= 4'h0;
      symCount <= 0;
      symFlips <= 0;
    end else begin
      slot_q <= slot_q + 3'h1;
      if (symValid && symReady) begin
        last_q   <= symData;
        symCount <= symCount + 1;
        if (symData != last_q) symFlips <= symFlips + 1;
      end
    end
  end
endmodule

/* File: bench/testbench.sv */
// Bench for register, rx state, packet and tone behaviour.
// Assumes modem_test_pkg and the rf_partner sink.
`timescale 1ns/1ns
module testbench
  import modem_test_pkg::*;
();
  // ------------
  // Signals
  // ------------
  logic        clk, arst_n, regWrite, regRead, rxForce, stall, symValid, symReady, pktActive;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata;
  logic [3:0]  symData;
  rx_state_t   rxStateNext, rxState;
  dac_sample_t dacSample;
  int          symCount, symFlips, errorCnt, totalChecks;
  int          cyc = 0;
  int          lastTake = 0;

  modem_test_gen #(.FIFO_DEPTH(8)) u_dut (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxStateNext(rxStateNext), .rxState(rxState), .rxForce(rxForce),
    .symValid(symValid), .symReady(symReady), .symData(symData),
    .pktActive(pktActive), .dacSample(dacSample));
  rf_partner u_rf (.clk(clk), .arst_n(arst_n), .stall(stall), .symValid(symValid),
    .symReady(symReady), .symData(symData), .symCount(symCount), .symFlips(symFlips));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle stamp of the latest symbol taken, for the gap check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (symValid && symReady) lastTake <= cyc;
  end

  // ------------
  // Tasks
  // ------------
  task automatic chk(input string name, input logic [15:0] exp, got);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Data is looked at just after the edge that sets it
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, regRdata});
  endtask
  task automatic wrd(input logic [15:0] a, input logic [7:0] w, e);
    wr(a, w);
    repeat (2) @(posedge clk);
    rd(a, e);
  endtask
  task automatic waitPkt(input logic lvl);
    for (int n = 0; n < 6000 && pktActive !== lvl; n++) begin
      @(posedge clk);
      #1;
    end
    chk("pktActive", {15'h0, lvl}, {15'h0, pktActive});
  endtask
  // Window ends half a slot before the next packet could start
  task automatic pkt(input logic [6:0] len);
    int win, c0, f0;
    win = (HEADER_SYMBOLS + 2 * len + 15) * SYMBOL_CYCLES - SYMBOL_CYCLES / 2;
    wrd(TEST_PACKET_LENGTH_ADDR, {1'b0, len}, {1'b0, len});
    wr(TEST_CONTROL_ADDR, 8'h41);
    waitPkt(1'b1);
    rd(TEST_CONTROL_ADDR, 8'h81);
    c0 = symCount;
    f0 = symFlips;
    repeat (win) @(posedge clk);
    chk("symbols", 16'(HEADER_SYMBOLS + 2 * len), 16'(symCount - c0));
    if (len > 7'h1) chk("symFlips", 16'h1, {15'h0, (symFlips - f0) > len});
    wr(TEST_CONTROL_ADDR, 8'h00);
    waitPkt(1'b0);
    // Control 0x41 set a gap of 15 slots; a refused cycle may take one off
    chk("gapCycles", 16'h1,
        {15'h0, (cyc - lastTake) inside {[15 * SYMBOL_CYCLES : 15 * SYMBOL_CYCLES + 1]}});
  endtask
  task automatic tone(input logic [7:0] step);
    dac_sample_t s [32];
    int p;
    logic same;
    p = 1024 / step;
    same = 1'b1;
    wrd(TONE_FREQUENCY_ADDR, step, step);
    wr(TEST_CONTROL_ADDR, 8'h12);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 32; k++) begin
      @(posedge clk);
      #1;
      s[k] = dacSample;
    end
    for (int k = 0; k < 16; k++) begin
      chk("tonePeriod", s[k], s[k + p]);
      chk("toneQuad", {8'h0, s[k].iData}, {8'h0, s[k + p / 4].qData});
      if (s[k] !== s[0]) same = 1'b0;
    end
    chk("toneMoves", 16'h0, {15'h0, same});
  endtask
  task automatic endOfTest();
    $display("Checks %0d, errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog sized above the longest packet run
  initial begin
    repeat (80000) @(posedge clk);
    errorCnt++;
    endOfTest();
  end

  // ------------
  // Sequence
  // ------------
  initial begin
    errorCnt = 0;
    totalChecks = 0;
    regAddr = 16'h0000;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    rxStateNext = RX_IDLE;
    stall = 1'b0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(RNG_SEED_ADDR, RNG_SEED_RESET);
    rd(TEST_PACKET_LENGTH_ADDR, PKT_LEN_RESET);
    rd(TONE_FREQUENCY_ADDR, TONE_STEP_RESET);
    rd(MODEM_STATE_STATUS_ADDR, 8'h80);
    wrd(RNG_SEED_ADDR, 8'hA5, 8'hA5);
    wrd(TEST_PACKET_LENGTH_ADDR, 8'h00, 8'h01);
    wrd(TONE_FREQUENCY_ADDR, 8'h02, 8'h04);
    wrd(16'h2300, 8'h5A, 8'h00);
    @(posedge clk);
    rxStateNext <= RX_PACKET_END;
    stall <= 1'b1;
    for (int c = 0; c < 5; c++) begin
      wrd(MODEM_STATE_STATUS_ADDR, {1'b0, 3'(c), 4'h0}, {1'b0, 3'(c), 4'h0});
      chk("rxState", 16'(c), {13'h0, rxState});
    end
    wrd(MODEM_STATE_STATUS_ADDR, 8'hC0, 8'hF0);
    pkt(PKT_LEN_MIN);
    pkt(PKT_LEN_MAX);
    tone(8'h40);
    tone(8'h80);
    wr(TEST_CONTROL_ADDR, 8'h2A);
    repeat (3) @(posedge clk);
    chk("dacMid", {DAC_MID, DAC_MID}, dacSample);
    endOfTest();
  end
endmodule
